//--- hw/plb_loopback_regs.sv
// plb_loopback_regs: test loopback paths and management register bits of a
// 10/100 transceiver digital core, registers reached over APB
// assumes: MAC and line codec logic on core_clk; status pins asynchronous
//
// Summary of operation
// - near loopback runs tx through coding stages
// - near loopback keeps collision low unless tested
// - near loopback powers line transmitter down
// - far loop echoes line receive to line
// - far loop isolates MAC side signals
// - far loop only works in RMII mode
// - registers addressed by clause 22 index
// - read-only bits ignore writes
// - write-only bits read back as zero
// - writing one clears, zero keeps
// - any write clears, read shows value
// - read clears bit, writes ignored
// - latch-low holds low until read
// - latch-high holds high until read
// - self-clearing bits return to zero
// - self-setting bits return to one
// - kept bits survive software reset
// - plain bits read back last write
// - control loopback bit enters near loopback unless far loop is active
// - collision test follows transmit enable unless MAC side isolated
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "plb_params.svh"
module plb_loopback_regs
   import plb_pkg::*;
#(
   parameter int LOOP_STAGES = 3
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire plb_apb_req_type apb_req,
   output plb_apb_rsp_type apb_rsp,
   input wire plb_nib_type mac_tx,
   output plb_nib_type mac_rx,
   output logic col,
   input wire plb_nib_type line_rx,
   output plb_nib_type line_tx,
   output logic line_tx_pwr,
   output logic mac_if_off,
   input wire logic rmii_pin,
   input wire logic link_pin,
   input wire logic remote_fault_pin,
   input wire logic jabber_pin,
   input wire logic ev_w1c,
   input wire logic ev_wac,
   input wire logic ev_rc,
   output logic restart_an_pulse,
   output logic test_strobe
);
   localparam int COL_ON_CYC =
      (`PLB_COL_ON_MAX_BT * `PLB_BIT_TIME_NS) / `PLB_CLK_PERIOD_NS;
   localparam int COL_OFF_CYC =
      (`PLB_COL_OFF_MAX_BT * `PLB_BIT_TIME_NS) / `PLB_CLK_PERIOD_NS;
   // named so that single reset bits can be selected from it
   localparam logic [15:0] MODE_RST_VAL = `PLB_MODE_RST;

   if (LOOP_STAGES < 1 || COL_ON_CYC < 1 || COL_OFF_CYC < 1) begin : g_chk
      $error("plb_loopback_regs: stage count or timing cannot be served");
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic rmii_s;
   logic link_s;
   logic rfault_s;
   logic jab_s;

   plb_sync u_sync_rmii (.core_clk(core_clk), .rst(rst), .ce(ce),
      .pin(rmii_pin), .level(rmii_s));
   plb_sync u_sync_link (.core_clk(core_clk), .rst(rst), .ce(ce),
      .pin(link_pin), .level(link_s));
   plb_sync u_sync_rf (.core_clk(core_clk), .rst(rst), .ce(ce),
      .pin(remote_fault_pin), .level(rfault_s));
   plb_sync u_sync_jab (.core_clk(core_clk), .rst(rst), .ce(ce),
      .pin(jabber_pin), .level(jab_s));

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic [4:0] idx;
   logic aligned;
   logic setup;
   logic acc;
   logic wr;
   logic rd;
   logic [15:0] wd;

   assign idx = apb_req.paddr[6:2];
   assign aligned = (apb_req.paddr[1:0] == 2'h0) && !apb_req.paddr[7];
   assign setup = apb_req.psel && !apb_req.penable;
   assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
   assign wr = acc && apb_req.pwrite && !apb_rsp.pslverr;
   assign rd = acc && !apb_req.pwrite && !apb_rsp.pslverr;
   assign wd = apb_req.pwdata[15:0];

   ////////////////////////////////////////////////////////////////////////
   // basic control register

   logic [15:0] ctrl;
   logic soft_rst;

   assign soft_rst = ctrl[`PLB_CTRL_SRST];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= `PLB_CTRL_RST;
      end else if (ce) begin
         if (soft_rst) begin
            ctrl <= `PLB_CTRL_RST;
         end else if (wr && idx == `PLB_IDX_CTRL) begin
            ctrl <= {wd[15:7], 7'h00};
         end else begin
            ctrl[`PLB_CTRL_RSTAN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         restart_an_pulse <= 1'b0;
      end else if (ce) begin
         restart_an_pulse <= !soft_rst && wr && idx == `PLB_IDX_CTRL && wd[`PLB_CTRL_RSTAN];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode control/status register

   logic far_loop_enable;
   logic kept_over_soft_reset;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         far_loop_enable <= MODE_RST_VAL[`PLB_MODE_FAR];
      end else if (ce) begin
         if (soft_rst) begin
            far_loop_enable <= MODE_RST_VAL[`PLB_MODE_FAR];
         end else if (wr && idx == `PLB_IDX_MODE) begin
            far_loop_enable <= wd[`PLB_MODE_FAR];
         end
      end
   end

   // hardware reset only; software reset leaves it alone
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         kept_over_soft_reset <= MODE_RST_VAL[`PLB_MODE_KEEP];
      end else if (ce && wr && idx == `PLB_IDX_MODE) begin
         kept_over_soft_reset <= wd[`PLB_MODE_KEEP];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // latched status bits of the basic status register

   logic link_ll;
   logic rfault_lh;
   logic jab_lh;
   logic rd_stat;

   // only what the reader saw is released, so nothing slips between phases
   assign rd_stat = rd && idx == `PLB_IDX_STAT;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         link_ll <= 1'b0;
      end else if (ce) begin
         if (rd_stat && !apb_rsp.prdata[`PLB_STAT_LINK]) begin
            link_ll <= link_s;
         end else begin
            link_ll <= link_ll && link_s;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rfault_lh <= 1'b0;
         jab_lh <= 1'b0;
      end else if (ce) begin
         rfault_lh <= rfault_s ||
            (rfault_lh && !(rd_stat && apb_rsp.prdata[`PLB_STAT_RFAULT]));
         jab_lh <= jab_s ||
            (jab_lh && !(rd_stat && apb_rsp.prdata[`PLB_STAT_JAB]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event register: clear styles and a self-setting bit

   logic evt_w1c;
   logic evt_wac;
   logic evt_rc;
   logic evt_ss;
   logic wr_evt;
   logic rd_evt;

   assign wr_evt = wr && idx == `PLB_IDX_EVT;
   assign rd_evt = rd && idx == `PLB_IDX_EVT;

   // hardware set always beats a clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         evt_w1c <= 1'b0;
         evt_wac <= 1'b0;
         evt_rc <= 1'b0;
      end else if (ce) begin
         if (soft_rst) begin
            evt_w1c <= ev_w1c;
            evt_wac <= ev_wac;
            evt_rc <= ev_rc;
         end else begin
            evt_w1c <= ev_w1c || (evt_w1c && !(wr_evt && wd[`PLB_EVT_W1C]));
            evt_wac <= ev_wac || (evt_wac && !wr_evt);
            evt_rc <= ev_rc ||
               (evt_rc && !(rd_evt && apb_rsp.prdata[`PLB_EVT_RC]));
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         evt_ss <= 1'b1;
      end else if (ce) begin
         if (!evt_ss) begin
            evt_ss <= 1'b1;
         end else if (!soft_rst && wr_evt && !wd[`PLB_EVT_SS]) begin
            evt_ss <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         test_strobe <= 1'b0;
      end else if (ce) begin
         test_strobe <= !soft_rst && wr_evt && wd[`PLB_EVT_WO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux and APB answer

   logic [15:0] rd_word;
   logic mapped;

   always_comb begin
      rd_word = 16'h0000;
      mapped = aligned;
      case (idx)
         `PLB_IDX_CTRL: rd_word = ctrl;
         `PLB_IDX_STAT: begin
            rd_word = `PLB_STAT_ABIL;
            rd_word[`PLB_STAT_RFAULT] = rfault_lh;
            rd_word[`PLB_STAT_LINK] = link_ll;
            rd_word[`PLB_STAT_JAB] = jab_lh;
         end
         `PLB_IDX_MODE: begin
            rd_word[`PLB_MODE_FAR] = far_loop_enable;
            rd_word[`PLB_MODE_RMII] = rmii_s;
            rd_word[`PLB_MODE_KEEP] = kept_over_soft_reset;
         end
         `PLB_IDX_EVT: begin
            rd_word[`PLB_EVT_W1C] = evt_w1c;
            rd_word[`PLB_EVT_WAC] = evt_wac;
            rd_word[`PLB_EVT_RC] = evt_rc;
            rd_word[`PLB_EVT_SS] = evt_ss;
         end
         default: mapped = 1'b0;
      endcase
   end

   // answer loaded during the setup phase: no wait state, and every answer signal on a flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         apb_rsp <= '0;
      end else if (ce) begin
         if (setup) begin
            apb_rsp.prdata <= {16'h0000, rd_word};
            apb_rsp.pready <= 1'b1;
            apb_rsp.pslverr <= !mapped;
         end else if (acc) begin
            apb_rsp.pready <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data path selection

   plb_path_type path;
   logic iso;
   logic near;
   logic far;

   always_comb begin
      if (far_loop_enable && rmii_s) begin
         path = PLB_FAR;
      end else if (ctrl[`PLB_CTRL_LOOP]) begin
         path = PLB_NEAR;
      end else begin
         path = PLB_NORMAL;
      end
   end

   assign far = (path == PLB_FAR);
   assign near = (path == PLB_NEAR);
   assign iso = far || ctrl[`PLB_CTRL_ISO];

   // coding, attachment and media-dependent stages of the transmit side
   plb_nib_type stage [LOOP_STAGES+1];

   assign stage[0] = iso ? plb_nib_type'('0) : mac_tx;

   for (genvar i = 0; i < LOOP_STAGES; i++) begin : g_stage
      plb_stage #(.WIDTH($bits(plb_nib_type))) u_stage (
         .core_clk(core_clk),
         .rst(rst),
         .ce(ce),
         .d(stage[i]),
         .q(stage[i+1])
      );
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mac_rx <= '0;
         line_tx <= '0;
         line_tx_pwr <= 1'b0;
         mac_if_off <= 1'b0;
      end else if (ce) begin
         mac_if_off <= iso;
         line_tx_pwr <= !near && !ctrl[`PLB_CTRL_PDN];
         case (path)
            PLB_FAR: begin
               mac_rx <= '0;
               line_tx <= line_rx;
            end
            PLB_NEAR: begin
               mac_rx <= stage[LOOP_STAGES];
               line_tx <= '0;
            end
            default: begin
               mac_rx <= ctrl[`PLB_CTRL_ISO] ? plb_nib_type'('0) : line_rx;
               line_tx <= ctrl[`PLB_CTRL_PDN] ? plb_nib_type'('0) : stage[LOOP_STAGES];
            end
         endcase
      end
   end

   // collision: one cycle after the cause, well inside both bit-time bounds
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         col <= 1'b0;
      end else if (ce) begin
         if (iso) begin
            col <= 1'b0;
         end else if (near) begin
            col <= ctrl[`PLB_CTRL_COLT] && mac_tx.en;
         end else begin
            col <= (ctrl[`PLB_CTRL_COLT] && mac_tx.en) ||
               (mac_tx.en && line_rx.en && !ctrl[`PLB_CTRL_DUPLEX]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_near_tx_off;
      @(posedge core_clk) disable iff (rst)
      (ce && near) |=> !line_tx_pwr && line_tx == '0;
   endproperty
   a_near_tx_off: assert property (p_near_tx_off)
      else $error("transmitter powered during near loopback");

   property p_near_col_quiet;
      @(posedge core_clk) disable iff (rst)
      (ce && near && !ctrl[`PLB_CTRL_COLT]) |=> !col;
   endproperty
   a_near_col_quiet: assert property (p_near_col_quiet)
      else $error("collision seen in near loopback without test");

   property p_far_echo;
      @(posedge core_clk) disable iff (rst)
      (ce && far) |=> line_tx == $past(line_rx) && mac_rx == '0 && mac_if_off;
   endproperty
   a_far_echo: assert property (p_far_echo)
      else $error("far loop did not echo line data or left MAC live");

   property p_far_rmii;
      @(posedge core_clk) disable iff (rst)
      (ce && far_loop_enable && !rmii_s && !ctrl[`PLB_CTRL_ISO]) |=> !mac_if_off;
   endproperty
   a_far_rmii: assert property (p_far_rmii)
      else $error("far loop entered outside RMII mode");

   property p_col_test;
      @(posedge core_clk) disable iff (rst)
      (ce && !iso && ctrl[`PLB_CTRL_COLT] && mac_tx.en) |=> col;
   endproperty
   a_col_test: assert property (p_col_test)
      else $error("collision test did not follow transmit enable");

   property p_w1c_zero;
      @(posedge core_clk) disable iff (rst)
      (ce && !soft_rst && wr_evt && !wd[`PLB_EVT_W1C]) |=>
         evt_w1c == $past(evt_w1c) || $past(ev_w1c);
   endproperty
   a_w1c_zero: assert property (p_w1c_zero)
      else $error("write of zero changed a write-one-clear bit");

   property p_soft_reset;
      @(posedge core_clk) disable iff (rst)
      (ce && soft_rst) |=> !soft_rst && ctrl == `PLB_CTRL_RST &&
         kept_over_soft_reset == $past(kept_over_soft_reset);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("software reset did not clear or did not keep bits");

   property p_self_set;
      @(posedge core_clk) disable iff (rst)
      (ce && !evt_ss) |=> evt_ss;
   endproperty
   a_self_set: assert property (p_self_set)
      else $error("self-setting bit did not return to one");

   property p_link_latch;
      @(posedge core_clk) disable iff (rst)
      (ce && !link_s && !link_ll) ##1 (ce && !rd_stat)[*2] |=> !link_ll;
   endproperty
   a_link_latch: assert property (p_link_latch)
      else $error("latch-low link bit rose before a read");

   property p_rw_back;
      @(posedge core_clk) disable iff (rst)
      (ce && !soft_rst && wr && idx == `PLB_IDX_CTRL && !wd[`PLB_CTRL_SRST]) |=>
         ctrl[`PLB_CTRL_COLT] == $past(wd[`PLB_CTRL_COLT]);
   endproperty
   a_rw_back: assert property (p_rw_back)
      else $error("plain bit did not keep written value");
endmodule : plb_loopback_regs

//--- pkg/plb_params.svh
// plb_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the loopback/register block and its package users
`ifndef PLB_PARAMS_SVH
`define PLB_PARAMS_SVH

// register indices; byte address is four times the index
`define PLB_IDX_CTRL 5'h00
`define PLB_IDX_STAT 5'h01
`define PLB_IDX_MODE 5'h11
`define PLB_IDX_EVT 5'h18

// basic control fields
`define PLB_CTRL_SRST 15
`define PLB_CTRL_LOOP 14
`define PLB_CTRL_SPEED 13
`define PLB_CTRL_ANEN 12
`define PLB_CTRL_PDN 11
`define PLB_CTRL_ISO 10
`define PLB_CTRL_RSTAN 9
`define PLB_CTRL_DUPLEX 8
`define PLB_CTRL_COLT 7

// basic status fields
`define PLB_STAT_ABIL 16'h7808
`define PLB_STAT_RFAULT 4
`define PLB_STAT_LINK 2
`define PLB_STAT_JAB 1

// mode control/status fields
`define PLB_MODE_FAR 9
`define PLB_MODE_RMII 2
`define PLB_MODE_KEEP 1

// event register fields
`define PLB_EVT_W1C 0
`define PLB_EVT_WAC 1
`define PLB_EVT_RC 2
`define PLB_EVT_SS 3
`define PLB_EVT_WO 4

// reset values
`define PLB_CTRL_RST 16'h3100
`define PLB_MODE_RST 16'h0000

// timing
`define PLB_CLK_PERIOD_NS 20
`define PLB_BIT_TIME_NS 10
`define PLB_COL_ON_MAX_BT 512
`define PLB_COL_OFF_MAX_BT 4

`endif

//--- pkg/plb_pkg.sv
// plb_pkg: types shared by the loopback/register block
// assumes: nothing beyond the standard language
package plb_pkg;
   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] d;
   } plb_nib_type;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } plb_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } plb_apb_rsp_type;

   typedef enum logic [1:0] {
      PLB_NORMAL = 2'b00,
      PLB_NEAR = 2'b01,
      PLB_FAR = 2'b10
   } plb_path_type;
endpackage : plb_pkg

//--- hw/plb_stage.sv
// plb_stage: one register stage of the digital transmit path
// assumes: same clock as its neighbours, clock enable freezes it
`timescale 1ns/10ps
module plb_stage #(
   parameter int WIDTH = 6
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   if (WIDTH < 1) begin : g_chk
      $error("plb_stage: WIDTH must be at least 1");
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
endmodule : plb_stage

//--- hw/plb_sync.sv
// plb_sync: three-flop synchroniser for a pin level
// assumes: input is asynchronous to core_clk
`timescale 1ns/10ps
module plb_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic pin,
   output logic level
);
   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
         level <= 1'b0;
      end else if (ce) begin
         ff1 <= pin;
         ff2 <= ff1;
         ff3 <= ff2;
         // change counts only once two late stages agree
         if (ff2 == ff3) begin
            level <= ff3;
         end
      end
   end
endmodule : plb_sync

//--- verification/plb_mac_model.sv
// plb_mac_model: MAC transmit nibbles and line receive nibbles for the bench
// assumes: shares core_clk with the block; tx_on from the bench gates tx enable
`timescale 1ns/10ps
module plb_mac_model
   import plb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tx_on,
   output plb_nib_type mac_tx,
   output plb_nib_type line_rx
);
   logic [3:0] cnt;

   // data keeps moving while idle so a stale value never passes for a match
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h3;
      end
   end

   // line side differs from the MAC side so a wrong path shows up
   assign mac_tx = {tx_on, 1'b0, cnt};
   assign line_rx = {1'b1, 1'b0, cnt ^ 4'ha};
endmodule : plb_mac_model

//--- verification/plb_loopback_regs_tb.sv
// plb_loopback_regs_tb: register bit kinds and loopback paths over APB
// assumes: plb_mac_model feeds MAC and line nibbles on the same clock
`timescale 1ns/10ps
`include "plb_params.svh"
module plb_loopback_regs_tb;
   import plb_pkg::*;
   localparam int LOOP_STAGES = 3;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tx_on = 1'b0;
   logic ce = 1'b1;
   plb_nib_type sv;
   logic rmii_pin = 1'b0;
   logic link_pin = 1'b0;
   logic rf_pin = 1'b0;
   logic jab_pin = 1'b0;
   logic [2:0] ev = 3'h0;
   plb_apb_req_type req = '0;
   plb_apb_rsp_type apb_rsp;
   plb_nib_type mac_tx, line_rx, mac_rx, line_tx;
   plb_nib_type txh [0:7];
   plb_nib_type rxh [0:7];
   logic col, line_tx_pwr, mac_if_off, an_p, ts_p, err;
   logic [15:0] rd;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int n_an = 0;
   int n_ts = 0;

   always #10 core_clk = ~core_clk;

   plb_mac_model plb_mac_model_inst (.core_clk(core_clk), .rst(rst), .tx_on(tx_on),
      .mac_tx(mac_tx), .line_rx(line_rx));

   plb_loopback_regs #(.LOOP_STAGES(LOOP_STAGES)) plb_loopback_regs_inst (
      .core_clk(core_clk), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(apb_rsp),
      .mac_tx(mac_tx), .mac_rx(mac_rx), .col(col), .line_rx(line_rx),
      .line_tx(line_tx), .line_tx_pwr(line_tx_pwr), .mac_if_off(mac_if_off),
      .rmii_pin(rmii_pin), .link_pin(link_pin), .remote_fault_pin(rf_pin),
      .jabber_pin(jab_pin), .ev_w1c(ev[0]), .ev_wac(ev[1]), .ev_rc(ev[2]),
      .restart_an_pulse(an_p), .test_strobe(ts_p));

   ////////////////////////////////////////////////////////////////////////////
   // history of offered nibbles, pulse counters, hang guard
   always @(posedge core_clk) begin
      txh[0] <= mac_tx;
      rxh[0] <= line_rx;
      for (int i = 7; i > 0; i--) begin
         txh[i] <= txh[i-1];
         rxh[i] <= rxh[i-1];
      end
      if (an_p === 1'b1) n_an++;
      if (ts_p === 1'b1) n_ts++;
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp,
         input logic [15:0] m);
      check_count++;
      if ((got & m) !== (exp & m)) begin
         n_fail++;
         $display("CHECK FAILED t=%0t reg %h exp %h", $time, got & m, exp & m);
      end
   endtask : chk_reg

   task automatic chk_nib(input plb_nib_type got, input plb_nib_type exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t nibble %h exp %h", $time, got, exp);
      end
   endtask : chk_nib

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
      end
   endtask : chk_bit

   // one APB transfer; request held until pready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
      @(posedge core_clk);
      req.paddr <= {1'b0, idx, 2'b00};
      req.pwrite <= wr;
      req.pwdata <= {16'h0, wd};
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge core_clk);
      req.penable <= 1'b1;
      do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata[15:0];
      err = apb_rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer

   task automatic rdchk(input logic [4:0] idx, input logic [15:0] exp, input logic [15:0] m);
      xfer(1'b0, idx, 16'h0);
      chk_reg(rd, exp, m);
   endtask : rdchk

   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask : hold

   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 3'h0;
   endtask : pulse

   // mode 0 normal, 1 near loopback, 2 far loopback
   task automatic watch(input int mode);
      repeat (8) begin
         @(negedge core_clk);
         if (mode == 0) begin
            chk_nib(line_tx, txh[LOOP_STAGES]);
            chk_nib(mac_rx, rxh[0]);
         end else if (mode == 1) begin
            chk_nib(mac_rx, txh[LOOP_STAGES]);
            chk_nib(line_tx, '0);
            chk_bit(line_tx_pwr, 1'b0);
            chk_bit(col, 1'b0);
         end else begin
            chk_nib(line_tx, rxh[0]);
            chk_nib(mac_rx, '0);
            chk_bit(mac_if_off, 1'b1);
         end
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rdchk(`PLB_IDX_CTRL, `PLB_CTRL_RST, 16'hffff);
      rdchk(`PLB_IDX_MODE, `PLB_MODE_RST, 16'h0202);
      xfer(1'b0, 5'h02, 16'h0);
      chk_bit(err, 1'b1);
      rdchk(`PLB_IDX_STAT, `PLB_STAT_ABIL, 16'hff08);
      chk_bit(err, 1'b0);
      xfer(1'b1, `PLB_IDX_STAT, 16'hffff);
      rdchk(`PLB_IDX_STAT, `PLB_STAT_ABIL, 16'hff08);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h2080);
      rdchk(`PLB_IDX_CTRL, 16'h2080, 16'hffff);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h2280);
      rdchk(`PLB_IDX_CTRL, 16'h2080, 16'hffff);
      chk_bit(n_an == 1, 1'b1);
      xfer(1'b1, `PLB_IDX_MODE, 16'h0002);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h8000);
      hold(2);
      rdchk(`PLB_IDX_CTRL, `PLB_CTRL_RST, 16'hffff);
      rdchk(`PLB_IDX_MODE, 16'h0002, 16'h0202);
      $display("test control done");
      link_pin <= 1'b1;
      hold(6);
      rdchk(`PLB_IDX_STAT, 16'h0000, 16'h0004);
      rdchk(`PLB_IDX_STAT, 16'h0004, 16'h0004);
      link_pin <= 1'b0;
      hold(6);
      link_pin <= 1'b1;
      hold(6);
      rdchk(`PLB_IDX_STAT, 16'h0000, 16'h0004);
      rdchk(`PLB_IDX_STAT, 16'h0004, 16'h0004);
      jab_pin <= 1'b1;
      rf_pin <= 1'b1;
      hold(6);
      jab_pin <= 1'b0;
      hold(6);
      rdchk(`PLB_IDX_STAT, 16'h0012, 16'h0012);
      rdchk(`PLB_IDX_STAT, 16'h0010, 16'h0012);
      $display("test status done");
      pulse(3'h7);
      rdchk(`PLB_IDX_EVT, 16'h0007, 16'h0007);
      rdchk(`PLB_IDX_EVT, 16'h0003, 16'h0007);
      xfer(1'b1, `PLB_IDX_EVT, 16'h0000);
      hold(3);
      rdchk(`PLB_IDX_EVT, 16'h0009, 16'h000b);
      xfer(1'b1, `PLB_IDX_EVT, 16'h0001);
      rdchk(`PLB_IDX_EVT, 16'h0000, 16'h0001);
      pulse(3'h4);
      xfer(1'b1, `PLB_IDX_EVT, 16'h0004);
      rdchk(`PLB_IDX_EVT, 16'h0004, 16'h0004);
      xfer(1'b1, `PLB_IDX_EVT, 16'h0010);
      hold(2);
      chk_bit(n_ts == 1, 1'b1);
      $display("test events done");
      tx_on <= 1'b1;
      hold(6);
      watch(0);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h7100);
      hold(6);
      watch(1);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h7180);
      hold(3);
      chk_bit(col, 1'b1);
      tx_on <= 1'b0;
      hold(3);
      chk_bit(col, 1'b0);
      tx_on <= 1'b1;
      xfer(1'b1, `PLB_IDX_CTRL, 16'h3100);
      xfer(1'b1, `PLB_IDX_MODE, 16'h0200);
      hold(6);
      chk_bit(mac_if_off, 1'b0);
      watch(0);
      rmii_pin <= 1'b1;
      hold(6);
      watch(2);
      xfer(1'b1, `PLB_IDX_MODE, 16'h0000);
      hold(6);
      watch(0);
      $display("test loopback done");
      // isolate plus power down: MAC side quiet, line transmitter off
      xfer(1'b1, `PLB_IDX_CTRL, 16'h2d00);
      hold(6);
      chk_bit(mac_if_off, 1'b1);
      chk_bit(line_tx_pwr, 1'b0);
      chk_nib(mac_rx, '0);
      chk_nib(line_tx, '0);
      xfer(1'b1, `PLB_IDX_CTRL, 16'h3100);
      hold(6);
      // clock enable low must freeze the receive path although line data moves
      ce <= 1'b0;
      hold(2);
      sv = mac_rx;
      hold(3);
      chk_nib(mac_rx, sv);
      ce <= 1'b1;
      $display("test isolate and freeze done");
      wrap_up();
   end
endmodule : plb_loopback_regs_tb
